/* File: dv/core_model.sv */
/*
  Core-side model: register bus cycles and interrupt entry/return pulses.
  Assumes one system clock; drives 1 ns after the rising edge.
*/
module core_model (
  input wire logic i_clk_sys, // system clock
  input wire logic [7:0] i_rdata, // read data from the unit
  output logic [7:0] o_addr, // register address
  output logic o_wr, // write strobe
  output logic o_rd, // read strobe
  output logic [7:0] o_wdata, // write data
  output logic o_entry, // interrupt entry pulse
  output logic o_return, // interrupt return pulse
  output logic [7:0] o_page // page loaded on entry
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    o_addr = 8'h00;
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_wdata = 8'h00;
    o_entry = 1'b0;
    o_return = 1'b0;
    o_page = 8'h00;
  end

  // ----------------------------------------------------------------------
  // bus cycles: hold one edge, then release to inverted values
  // ----------------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    #1;
    o_addr = a;
    o_wdata = d;
    o_wr = 1'b1;
    @(posedge i_clk_sys);
    #1;
    o_wr = 1'b0;
    o_addr = ~a;
    o_wdata = ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clk_sys);
    #1;
    o_addr = a;
    o_rd = 1'b1;
    @(posedge i_clk_sys);
    #1;
    d = i_rdata;
    o_rd = 1'b0;
    o_addr = ~a;
  endtask

  // push on entry, pop on return, one pulse each
  task automatic evt(input logic push, input logic [7:0] pg);
    @(posedge i_clk_sys);
    #1;
    o_entry = push;
    o_return = !push;
    o_page = pg;
    @(posedge i_clk_sys);
    #1;
    o_entry = 1'b0;
    o_return = 1'b0;
    o_page = ~pg;
  endtask
endmodule

/* File: dv/tb.sv */
/*
  Self-checking bench for the extended interrupt enable unit.
  Assumes the core model drives the register bus; flags come from here.
*/
module tb;
  import irq_ext_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] addr, wdata, rdata, cur_page, entry_page;
  logic wr, rd, entry, ret;
  source_flags_s flags = '0;
  logic [6:0] dma_active = 7'h00;
  logic [6:0][15:0] offset = '0;
  logic [6:0][15:0] size = '0;
  logic [15:0] irq_req;
  int miscompares = 0;
  int num_checks = 0;

  always #25 clk_sys = ~clk_sys;

  core_model i_core (.i_clk_sys(clk_sys), .i_rdata(rdata), .o_addr(addr),
    .o_wr(wr), .o_rd(rd), .o_wdata(wdata), .o_entry(entry),
    .o_return(ret), .o_page(entry_page));

  extended_interrupt_enable_unit i_dut (.i_clk_sys(clk_sys),
    .i_resetn(resetn), .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_rd(rd),
    .i_reg_wdata(wdata), .i_irq_entry(entry), .i_irq_return(ret),
    .i_entry_page(entry_page), .i_flags(flags), .i_dma_active(dma_active),
    .i_offset(offset), .i_size(size), .o_reg_rdata(rdata),
    .o_current_page(cur_page), .o_irq_req(irq_req));

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  task automatic stop_test;
    $display("checks=%0d miscompares=%0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    i_core.rd(a, d);
    chk({8'h00, d}, {8'h00, exp});
  endtask

  task automatic set_en(input logic [15:0] e);
    i_core.wr(ADDR_EXTENDED_IRQ_ENABLE_FIRST, e[15:8]);
    i_core.wr(ADDR_EXTENDED_IRQ_ENABLE_SECOND, e[7:0]);
    step(2);
  endtask

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset;
    rdchk(ADDR_EXTENDED_IRQ_ENABLE_FIRST, RST_BYTE);
    rdchk(ADDR_EXTENDED_IRQ_ENABLE_SECOND, RST_BYTE);
    rdchk(ADDR_PAGE_STACK_SECOND_ENTRY, RST_BYTE);
    rdchk(ADDR_DMA_MIDPOINT_FLAGS, RST_BYTE);
    chk(irq_req, 16'h0000);
    i_core.wr(8'h00, 8'hFF);
    rdchk(8'h00, 8'h00);
    set_en(16'hA55A);
    rdchk(ADDR_EXTENDED_IRQ_ENABLE_FIRST, 8'hA5);
    rdchk(ADDR_EXTENDED_IRQ_ENABLE_SECOND, 8'h5A);
    $display("test reset done");
  endtask

  task automatic t_gates;
    logic [15:0] bit_k;
    for (int alt = 0; alt < 2; alt++) begin
      for (int k = 0; k < 16; k++) begin
        bit_k = 16'h0001 << k;
        // paired sources: each flag of the pair on one pass
        flags = (k < 13) ? 19'h00001 << k : 19'h00001 << (2 * k - 13 + alt);
        set_en(bit_k);
        chk(irq_req, bit_k);
        flags = '1;
        set_en(~bit_k);
        chk(irq_req, ~bit_k);
      end
    end
    set_en(16'h0000);
    chk(irq_req, 16'h0000);
    flags = '0;
    $display("test gates done");
  endtask

  task automatic t_stack;
    i_core.wr(ADDR_CURRENT_PAGE, 8'h11);
    i_core.evt(1'b1, 8'h22);
    i_core.evt(1'b1, 8'h33);
    step(2);
    chk({8'h00, cur_page}, 16'h0033);
    rdchk(ADDR_PAGE_STACK_SECOND_ENTRY, 8'h22);
    rdchk(ADDR_PAGE_STACK_THIRD_ENTRY, 8'h11);
    i_core.wr(ADDR_PAGE_STACK_SECOND_ENTRY, 8'h5A);
    rdchk(ADDR_PAGE_STACK_SECOND_ENTRY, 8'h5A);
    rdchk(ADDR_PAGE_STACK_THIRD_ENTRY, 8'h11);
    rdchk(ADDR_CURRENT_PAGE, 8'h33);
    i_core.evt(1'b0, 8'h00);
    step(2);
    chk({8'h00, cur_page}, 16'h005A);
    rdchk(ADDR_PAGE_STACK_SECOND_ENTRY, 8'h11);
    i_core.evt(1'b0, 8'h00);
    step(2);
    chk({8'h00, cur_page}, 16'h0011);
    $display("test stack done");
  endtask

  task automatic t_midpoint;
    size[0] = 16'h0005;
    size[1] = 16'h0008;
    dma_active = 7'h03;
    i_core.wr(ADDR_CHANNEL_SELECT, 8'h00);
    i_core.wr(ADDR_CHANNEL_CONFIG, 8'h40);
    rdchk(ADDR_CHANNEL_CONFIG, 8'h40);
    set_en(16'h0020);
    offset[0] = 16'h0002;
    offset[1] = 16'h0003;
    step(2);
    rdchk(ADDR_DMA_MIDPOINT_FLAGS, 8'h00);
    offset[0] = 16'h0003;
    offset[1] = 16'h0004;
    step(2);
    rdchk(ADDR_DMA_MIDPOINT_FLAGS, 8'h03);
    chk(irq_req, 16'h0020);
    offset[0] = 16'h0004;
    offset[1] = 16'h0005;
    step(4);
    rdchk(ADDR_DMA_MIDPOINT_FLAGS, 8'h03);
    i_core.wr(ADDR_DMA_MIDPOINT_FLAGS, 8'h82);
    rdchk(ADDR_DMA_MIDPOINT_FLAGS, 8'h02);
    set_en(16'h0000);
    rdchk(ADDR_DMA_MIDPOINT_FLAGS, 8'h02);
    set_en(16'h0020);
    step(2);
    chk(irq_req, 16'h0000);
    i_core.wr(ADDR_CHANNEL_SELECT, 8'h01);
    i_core.wr(ADDR_CHANNEL_CONFIG, 8'h40);
    step(2);
    chk(irq_req, 16'h0020);
    i_core.wr(ADDR_DMA_MIDPOINT_FLAGS, 8'h00);
    step(2);
    chk(irq_req, 16'h0000);
    i_core.wr(ADDR_CHANNEL_SELECT, 8'h07);
    i_core.wr(ADDR_CHANNEL_CONFIG, 8'h00);
    rdchk(ADDR_CHANNEL_CONFIG, 8'h00);
    i_core.wr(ADDR_CHANNEL_SELECT, 8'h01);
    rdchk(ADDR_CHANNEL_CONFIG, 8'h40);
    dma_active = 7'h00;
    $display("test midpoint done");
  endtask

  // ----------------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clk_sys);
    #1;
    resetn = 1'b1;
    t_reset();
    t_gates();
    t_stack();
    t_midpoint();
    stop_test();
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    miscompares++;
    $display("Error t=%0t timeout got=%h exp=%h", $time, 1'b0, 1'b1);
    stop_test();
  end
endmodule

/* File: hw/extended_interrupt_enable_unit.sv */
/*
  Extended interrupt enable unit: two enable registers gating sixteen
  request groups, a three-byte page-context stack and the DMA mid-point
  flag bank. Assumes a single-cycle register bus from the core on the
  system clock and level source flags from peripherals on the same clock.
*/
// Behaviour
// - first enable bit 7 gates timer 3 low or high overflow requests.
// - first enable bit 6 gates comparator 1 rise or fall requests.
// - first enable bit 5 gates comparator 0 rise or fall requests.
// - first enable bit 4 gates all counter array requests.
// - first enable bit 3 gates conversion done request.
// - first enable bit 2 gates window compare request.
// - first enable bit 1 gates clock alarm request.
// - first enable bit 0 gates all two-wire bus requests.
// - second enable bit 7 gates cipher engine requests.
// - second enable bit 6 gates encoder requests.
// - second enable bit 5 gates DMA requests.
// - second enable bit 4 gates pulse counter requests.
// - second enable bit 3 gates second SPI requests.
// - second enable bit 2 gates clock oscillator fail request.
// - second enable bit 1 gates port match requests.
// - second enable bit 0 gates supply early warning request.
// - three-entry page stack pushes on entry, pops on return only.
// - byte accesses to stack change only that byte, never shift.
// - second stack byte is page restored on next return; reads back.
// - mid-point flag sets when offset reaches half the transfer size.
// - software clears mid-point flags; bit 7 reads zero.
// - mid-point enable per channel via config bit 6 with selected channel.
module extended_interrupt_enable_unit
  import irq_ext_pkg::*;
(
  input wire logic i_clk_sys, // system clock, 20 MHz
  input wire logic i_resetn, // synchronous reset, active low
  input wire logic [7:0] i_reg_addr, // register address
  input wire logic i_reg_wr, // register write strobe
  input wire logic i_reg_rd, // register read strobe
  input wire logic [7:0] i_reg_wdata, // register write data
  input wire logic i_irq_entry, // core enters an interrupt
  input wire logic i_irq_return, // core returns from interrupt
  input wire logic [7:0] i_entry_page, // page loaded on entry
  input wire source_flags_s i_flags, // peripheral source flags
  input wire logic [6:0] i_dma_active, // channel transfer running
  input wire logic [6:0][15:0] i_offset, // channel offset address
  input wire logic [6:0][15:0] i_size, // channel transfer size
  output logic [7:0] o_reg_rdata, // register read data
  output logic [7:0] o_current_page, // current page to decode
  output logic [15:0] o_irq_req // gated requests to core
);

  // ----------------------------------------------------------------------
  // enable registers
  // ----------------------------------------------------------------------
  logic [7:0] extended_irq_enable_first;
  logic [7:0] extended_irq_enable_second;

  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      extended_irq_enable_first <= RST_BYTE;
      extended_irq_enable_second <= RST_BYTE;
    end else if (i_reg_wr) begin
      if (i_reg_addr == ADDR_EXTENDED_IRQ_ENABLE_FIRST) begin
        extended_irq_enable_first <= i_reg_wdata;
      end
      if (i_reg_addr == ADDR_EXTENDED_IRQ_ENABLE_SECOND) begin
        extended_irq_enable_second <= i_reg_wdata;
      end
    end
  end

  // ----------------------------------------------------------------------
  // page context stack
  // ----------------------------------------------------------------------
  logic [7:0] current_page;
  logic [7:0] page_stack_second_entry;
  logic [7:0] page_stack_third_entry;

  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      current_page <= RST_BYTE;
      page_stack_second_entry <= RST_BYTE;
      page_stack_third_entry <= RST_BYTE;
    end else if (i_irq_entry) begin
      current_page <= i_entry_page;
      page_stack_second_entry <= current_page;
      page_stack_third_entry <= page_stack_second_entry;
    end else if (i_irq_return) begin
      current_page <= page_stack_second_entry;
      page_stack_second_entry <= page_stack_third_entry;
    end else if (i_reg_wr) begin
      // byte writes never shift the stack
      case (i_reg_addr)
        ADDR_CURRENT_PAGE: current_page <= i_reg_wdata;
        ADDR_PAGE_STACK_SECOND_ENTRY: page_stack_second_entry <= i_reg_wdata;
        ADDR_PAGE_STACK_THIRD_ENTRY: page_stack_third_entry <= i_reg_wdata;
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // DMA channel config and mid-point flags
  // ----------------------------------------------------------------------
  logic [2:0] channel_select_field;
  logic [6:0] midpoint_enable;
  logic [6:0] channel_midpoint_flag;
  logic [6:0] midpoint_hit;
  logic [6:0] hit_seen;

  // threshold: half of size, odd sizes rounded up
  function automatic logic [15:0] half_size(input logic [15:0] size);
    half_size = (size >> 1) + {15'h0000, size[0]};
  endfunction

  always_comb begin
    for (int c = 0; c < NUM_CHANNELS; c++) begin
      midpoint_hit[c] = i_dma_active[c] &&
        (i_offset[c] == half_size(i_size[c]));
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      channel_select_field <= RST_CHANNEL_SEL;
      midpoint_enable <= RST_CHANNEL_BITS;
    end else if (i_reg_wr) begin
      if (i_reg_addr == ADDR_CHANNEL_SELECT) begin
        channel_select_field <= i_reg_wdata[2:0];
      end
      if (i_reg_addr == ADDR_CHANNEL_CONFIG &&
          channel_select_field < 3'h7) begin
        midpoint_enable[channel_select_field] <=
          i_reg_wdata[BIT_MIDPOINT_ENABLE];
      end
    end
  end

  // one set per reach of the threshold, not per cycle held there
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      hit_seen <= RST_CHANNEL_BITS;
    end else begin
      hit_seen <= midpoint_hit;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      channel_midpoint_flag <= RST_CHANNEL_BITS;
    end else begin
      for (int c = 0; c < NUM_CHANNELS; c++) begin
        if (midpoint_hit[c] && !hit_seen[c]) begin
          channel_midpoint_flag[c] <= 1'b1; // set wins over clear
        end else if (i_reg_wr && i_reg_addr == ADDR_DMA_MIDPOINT_FLAGS) begin
          channel_midpoint_flag[c] <= i_reg_wdata[c];
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // request gating
  // ----------------------------------------------------------------------
  logic [15:0] next_irq_req;
  logic dma_request;

  always_comb begin
    dma_request = i_flags.dma ||
      (|(channel_midpoint_flag & midpoint_enable));
    next_irq_req[15] = extended_irq_enable_first[BIT_TIMER3] &&
      (i_flags.timer3_low_overflow_flag ||
       i_flags.timer3_high_overflow_flag);
    next_irq_req[14] = extended_irq_enable_first[BIT_COMPARATOR1] &&
      (i_flags.comparator1_rise_flag ||
       i_flags.comparator1_fall_flag);
    next_irq_req[13] = extended_irq_enable_first[BIT_COMPARATOR0] &&
      (i_flags.comparator0_rise_flag ||
       i_flags.comparator0_fall_flag);
    next_irq_req[12] = extended_irq_enable_first[BIT_COUNTER_ARRAY] &&
      i_flags.counter_array;
    next_irq_req[11] = extended_irq_enable_first[BIT_CONVERSION_DONE] &&
      i_flags.conversion_done_flag;
    next_irq_req[10] = extended_irq_enable_first[BIT_WINDOW_COMPARE] &&
      i_flags.window_compare_flag;
    next_irq_req[9] = extended_irq_enable_first[BIT_RTC_ALARM] &&
      i_flags.rtc_alarm;
    next_irq_req[8] = extended_irq_enable_first[BIT_TWOWIRE] &&
      i_flags.twowire;
    next_irq_req[7] = extended_irq_enable_second[BIT_CIPHER] &&
      i_flags.cipher;
    next_irq_req[6] = extended_irq_enable_second[BIT_ENCODER] &&
      i_flags.encoder;
    next_irq_req[5] = extended_irq_enable_second[BIT_DMA] &&
      dma_request;
    next_irq_req[4] = extended_irq_enable_second[BIT_PULSE_COUNT] &&
      i_flags.pulse_count;
    next_irq_req[3] = extended_irq_enable_second[BIT_SECOND_SPI] &&
      i_flags.second_spi;
    next_irq_req[2] = extended_irq_enable_second[BIT_RTC_OSC_FAIL] &&
      i_flags.rtc_osc_fail;
    next_irq_req[1] = extended_irq_enable_second[BIT_PORT_MATCH] &&
      i_flags.port_match;
    next_irq_req[0] = extended_irq_enable_second[BIT_SUPPLY_WARNING] &&
      i_flags.supply_warning;
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      o_irq_req <= 16'h0000;
    end else begin
      o_irq_req <= next_irq_req;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      o_current_page <= RST_BYTE;
    end else begin
      o_current_page <= current_page;
    end
  end

  // ----------------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------------
  logic [7:0] next_rdata;

  always_comb begin
    case (i_reg_addr)
      ADDR_EXTENDED_IRQ_ENABLE_FIRST: next_rdata = extended_irq_enable_first;
      ADDR_EXTENDED_IRQ_ENABLE_SECOND: next_rdata = extended_irq_enable_second;
      ADDR_CURRENT_PAGE: next_rdata = current_page;
      ADDR_PAGE_STACK_SECOND_ENTRY: next_rdata = page_stack_second_entry;
      ADDR_PAGE_STACK_THIRD_ENTRY: next_rdata = page_stack_third_entry;
      ADDR_DMA_MIDPOINT_FLAGS: next_rdata = {1'b0, channel_midpoint_flag};
      ADDR_CHANNEL_SELECT: next_rdata = {5'h00, channel_select_field};
      ADDR_CHANNEL_CONFIG: next_rdata =
        (channel_select_field < 3'h7 && midpoint_enable[channel_select_field])
        ? 8'h40 : 8'h00;
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      o_reg_rdata <= RST_BYTE;
    end else if (i_reg_rd) begin
      o_reg_rdata <= next_rdata;
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  a_timer3_gate: assert property (
    @(posedge i_clk_sys) disable iff (!i_resetn)
    extended_irq_enable_first[BIT_TIMER3] &&
    (i_flags.timer3_low_overflow_flag || i_flags.timer3_high_overflow_flag)
    |=> o_irq_req[15])
    else $error("timer 3 request blocked");
  a_comp1_pass: assert property (
    @(posedge i_clk_sys) disable iff (!i_resetn)
    extended_irq_enable_first[BIT_COMPARATOR1] &&
    (i_flags.comparator1_rise_flag || i_flags.comparator1_fall_flag)
    |=> o_irq_req[14])
    else $error("comparator 1 request blocked");
  a_comp0_pass: assert property (
    @(posedge i_clk_sys) disable iff (!i_resetn)
    extended_irq_enable_first[BIT_COMPARATOR0] &&
    (i_flags.comparator0_rise_flag || i_flags.comparator0_fall_flag)
    |=> o_irq_req[13])
    else $error("comparator 0 request blocked");
  a_counter_pass: assert property (
    @(posedge i_clk_sys) disable iff (!i_resetn)
    extended_irq_enable_first[BIT_COUNTER_ARRAY] &&
    i_flags.counter_array |=> o_irq_req[12])
    else $error("counter array request blocked");
  a_conv_pass: assert property (
    @(posedge i_clk_sys) disable iff (!i_resetn)
    extended_irq_enable_first[BIT_CONVERSION_DONE] &&
    i_flags.conversion_done_flag |=> o_irq_req[11])
    else $error("conversion done request blocked");
  a_window_pass: assert property (
    @(posedge i_clk_sys) disable iff (!i_resetn)
    extended_irq_enable_first[BIT_WINDOW_COMPARE] &&
    i_flags.window_compare_flag |=> o_irq_req[10])
    else $error("window compare request blocked");
  a_alarm_pass: assert property (
    @(posedge i_clk_sys) disable iff (!i_resetn)
    extended_irq_enable_first[BIT_RTC_ALARM] &&
    i_flags.rtc_alarm |=> o_irq_req[9])
    else $error("clock alarm request blocked");
  a_twowire_pass: assert property (
    @(posedge i_clk_sys) disable iff (!i_resetn)
    extended_irq_enable_first[BIT_TWOWIRE] && i_flags.twowire |=> o_irq_req[8])
    else $error("two-wire request blocked");
  a_cipher_pass: assert property (
    @(posedge i_clk_sys) disable iff (!i_resetn)
    extended_irq_enable_second[BIT_CIPHER] && i_flags.cipher |=> o_irq_req[7])
    else $error("cipher request blocked");
  a_encoder_pass: assert property (
    @(posedge i_clk_sys) disable iff (!i_resetn)
    extended_irq_enable_second[BIT_ENCODER] &&
    i_flags.encoder |=> o_irq_req[6])
    else $error("encoder request blocked");
  a_dma_pass: assert property (
    @(posedge i_clk_sys) disable iff (!i_resetn)
    extended_irq_enable_second[BIT_DMA] && i_flags.dma |=> o_irq_req[5])
    else $error("dma request blocked");
  a_pulse_pass: assert property (
    @(posedge i_clk_sys) disable iff (!i_resetn)
    extended_irq_enable_second[BIT_PULSE_COUNT] &&
    i_flags.pulse_count |=> o_irq_req[4])
    else $error("pulse counter request blocked");
  a_spi_pass: assert property (
    @(posedge i_clk_sys) disable iff (!i_resetn)
    extended_irq_enable_second[BIT_SECOND_SPI] &&
    i_flags.second_spi |=> o_irq_req[3])
    else $error("second spi request blocked");
  a_oscfail_pass: assert property (
    @(posedge i_clk_sys) disable iff (!i_resetn)
    extended_irq_enable_second[BIT_RTC_OSC_FAIL] &&
    i_flags.rtc_osc_fail |=> o_irq_req[2])
    else $error("oscillator fail request blocked");
  a_match_pass: assert property (
    @(posedge i_clk_sys) disable iff (!i_resetn)
    extended_irq_enable_second[BIT_PORT_MATCH] &&
    i_flags.port_match |=> o_irq_req[1])
    else $error("port match request blocked");
  a_warning_pass: assert property (
    @(posedge i_clk_sys) disable iff (!i_resetn)
    extended_irq_enable_second[BIT_SUPPLY_WARNING] &&
    i_flags.supply_warning |=> o_irq_req[0])
    else $error("supply warning request blocked");
  a_gate_masked: assert property (
    @(posedge i_clk_sys) disable iff (!i_resetn)
    1'b1 |=> (o_irq_req & ~{$past(extended_irq_enable_first),
      $past(extended_irq_enable_second)}) == 16'h0000)
    else $error("request passed while masked");
  a_stack_push: assert property (
    @(posedge i_clk_sys) disable iff (!i_resetn)
    i_irq_entry |=> current_page == $past(i_entry_page) &&
    page_stack_second_entry == $past(current_page) &&
    page_stack_third_entry == $past(page_stack_second_entry))
    else $error("stack push wrong");
  a_stack_pop: assert property (
    @(posedge i_clk_sys) disable iff (!i_resetn)
    i_irq_return && !i_irq_entry |=>
    current_page == $past(page_stack_second_entry) &&
    page_stack_second_entry == $past(page_stack_third_entry))
    else $error("stack pop wrong");
  a_stack_still: assert property (
    @(posedge i_clk_sys) disable iff (!i_resetn)
    !i_irq_entry && !i_irq_return && !i_reg_wr |=>
    $stable(current_page) && $stable(page_stack_second_entry) &&
    $stable(page_stack_third_entry))
    else $error("stack moved without cause");
  a_stack_write: assert property (
    @(posedge i_clk_sys) disable iff (!i_resetn)
    i_reg_wr && i_reg_addr == ADDR_PAGE_STACK_SECOND_ENTRY &&
    !i_irq_entry && !i_irq_return |=>
    page_stack_second_entry == $past(i_reg_wdata) &&
    $stable(current_page) && $stable(page_stack_third_entry))
    else $error("stack byte write wrong");
  a_flag_sets: assert property (
    @(posedge i_clk_sys) disable iff (!i_resetn)
    midpoint_hit[0] && !hit_seen[0] |=> channel_midpoint_flag[0])
    else $error("mid-point flag not set");
  a_flag_bit7_zero: assert property (
    @(posedge i_clk_sys) disable iff (!i_resetn)
    i_reg_rd && i_reg_addr == ADDR_DMA_MIDPOINT_FLAGS |=>
    !o_reg_rdata[7])
    else $error("flag bit 7 read nonzero");
  a_flag_sticky: assert property (
    @(posedge i_clk_sys) disable iff (!i_resetn)
    channel_midpoint_flag[0] && !(i_reg_wr &&
    i_reg_addr == ADDR_DMA_MIDPOINT_FLAGS) |=> channel_midpoint_flag[0])
    else $error("mid-point flag cleared by hardware");
  a_flag_clear: assert property (
    @(posedge i_clk_sys) disable iff (!i_resetn)
    i_reg_wr && i_reg_addr == ADDR_DMA_MIDPOINT_FLAGS &&
    !i_reg_wdata[0] && !midpoint_hit[0] |=> !channel_midpoint_flag[0])
    else $error("mid-point flag not cleared");
  a_dma_midpoint_req: assert property (
    @(posedge i_clk_sys) disable iff (!i_resetn)
    extended_irq_enable_second[BIT_DMA] &&
    (|(channel_midpoint_flag & midpoint_enable)) |=> o_irq_req[5])
    else $error("mid-point request blocked");

endmodule

/* File: hw/irq_ext_pkg.sv */
/*
  Constants, register map and carrier types for the extended interrupt
  enable unit. Assumes an 8-bit special-register bus driven by the core.
*/
package irq_ext_pkg;

  // ----------------------------------------------------------------------
  // register addresses
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_PAGE_STACK_SECOND_ENTRY = 8'h85;
  localparam logic [7:0] ADDR_DMA_MIDPOINT_FLAGS = 8'hD4;
  localparam logic [7:0] ADDR_EXTENDED_IRQ_ENABLE_FIRST = 8'hE6;
  localparam logic [7:0] ADDR_EXTENDED_IRQ_ENABLE_SECOND = 8'hE7;
  localparam logic [7:0] ADDR_CURRENT_PAGE = 8'hA7;
  localparam logic [7:0] ADDR_PAGE_STACK_THIRD_ENTRY = 8'h86;
  localparam logic [7:0] ADDR_CHANNEL_CONFIG = 8'hD5;
  localparam logic [7:0] ADDR_CHANNEL_SELECT = 8'hD6;

  // ----------------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [6:0] RST_CHANNEL_BITS = 7'h00;
  localparam logic [2:0] RST_CHANNEL_SEL = 3'h0;

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int BIT_TIMER3 = 7;
  localparam int BIT_COMPARATOR1 = 6;
  localparam int BIT_COMPARATOR0 = 5;
  localparam int BIT_COUNTER_ARRAY = 4;
  localparam int BIT_CONVERSION_DONE = 3;
  localparam int BIT_WINDOW_COMPARE = 2;
  localparam int BIT_RTC_ALARM = 1;
  localparam int BIT_TWOWIRE = 0;
  localparam int BIT_CIPHER = 7;
  localparam int BIT_ENCODER = 6;
  localparam int BIT_DMA = 5;
  localparam int BIT_PULSE_COUNT = 4;
  localparam int BIT_SECOND_SPI = 3;
  localparam int BIT_RTC_OSC_FAIL = 2;
  localparam int BIT_PORT_MATCH = 1;
  localparam int BIT_SUPPLY_WARNING = 0;
  localparam int BIT_MIDPOINT_ENABLE = 6;
  localparam int NUM_CHANNELS = 7;

  // ----------------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic timer3_low_overflow_flag;
    logic timer3_high_overflow_flag;
    logic comparator1_rise_flag;
    logic comparator1_fall_flag;
    logic comparator0_rise_flag;
    logic comparator0_fall_flag;
    logic counter_array;
    logic conversion_done_flag;
    logic window_compare_flag;
    logic rtc_alarm;
    logic twowire;
    logic cipher;
    logic encoder;
    logic dma;
    logic pulse_count;
    logic second_spi;
    logic rtc_osc_fail;
    logic port_match;
    logic supply_warning;
  } source_flags_s;

  typedef struct packed {
    logic [6:0] transfer_done_event;
    logic [6:0] offset_step;
  } dma_status_s;

endpackage
